// *** src/sq_mf_consts.svh ***
/*
  Constants of the S/Q multiframe block: frame positions, timing counts.
  Assumes a 100 MHz system clock and a 4 kHz S-frame rate.
*/
`ifndef SQ_MF_CONSTS_SVH
`define SQ_MF_CONSTS_SVH

// Clock and frame rates as figures
`define CLOCK_HZ        100000000
`define FRAME_RATE_HZ   4000
// Cycles per S-frame derived from the rates
`define FRAME_CYCLES    (`CLOCK_HZ / `FRAME_RATE_HZ)
// Trigger counts as present while seen within this many frames
`define TRIG_HOLD_FRAMES 2

// Multiframe positions, frame 1 is index 0
`define MF_FIRST_IDX    5'h00
`define MF_LAST_IDX     5'h13
`define MF_FRAMES       5'h14
`define Q_FRAME_1_IDX   5'h00
`define Q_FRAME_2_IDX   5'h05
`define Q_FRAME_3_IDX   5'h0A
`define Q_FRAME_4_IDX   5'h0F

`endif

// *** src/sq_mf_pkg.sv ***
/*
  Types of the S/Q multiframe block: state records and tracker states.
  Assumes the constants header is used for all numbers.
*/
package sq_mf_pkg;

   // Terminal-side M-bit tracker states
   typedef enum logic [1:0] {
      TRK_HUNT   = 2'b00,
      TRK_CHECK  = 2'b01,
      TRK_LOCKED = 2'b10
   } trk_state_type;

   // Whole state of the multiframe core
   typedef struct packed {
      logic        trig_d;
      logic [15:0] timer;
      logic [15:0] ext_age;
      logic [4:0]  frame_idx;
      logic        msync_taken;
      logic        msync_val;
      logic        sync_hit;
      logic        frame_start;
      logic        fa;
      logic        m;
      logic        s;
      logic [3:0]  q_bits;
      logic        irq;
      logic        pin_out;
      logic        pin_oe;
      logic        locked;
   } core_state_type;

   // Whole state of the M-bit tracker
   typedef struct packed {
      trk_state_type st;
      logic [4:0]    idx;
      logic [4:0]    cnt;
   } trk_rec_type;

   // Whole state of a two-stage synchroniser
   typedef struct packed {
      logic [1:0] stage;
   } sync_rec_type;

endpackage

// *** src/m_track_if.sv ***
/*
  Carrier between the multiframe core and the M-bit tracker.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

interface m_track_if;
   logic m_valid;
   logic m_bit;
   logic locked;

   modport core    (output m_valid, output m_bit, input locked);
   modport tracker (input m_valid, input m_bit, output locked);
endinterface

`default_nettype wire

// *** src/pin_sync2.sv ***
/*
  Two-flip-flop synchroniser for one pin level.
  Assumes the pin is asynchronous to clock_i.
*/
`timescale 1ns/1ns
`default_nettype none

module pin_sync2
(
   input  wire logic clock_i,
   input  wire logic rst_b_i,
   input  wire logic pin_i,
   output logic      level_o
);

   sq_mf_pkg::sync_rec_type state_ff;
   sq_mf_pkg::sync_rec_type nxt_state;

   // Shift the pin through two stages, only the second is read
   always_comb
   begin
      nxt_state.stage = {state_ff.stage[0], pin_i};
   end

   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         state_ff <= '0;
      else
         state_ff <= nxt_state;
   end

   assign level_o = state_ff.stage[1];

endmodule

`default_nettype wire

// *** src/m_bit_tracker.sv ***
/*
  Terminal-side multiframe lock on the received M bit.
  Assumes one m_valid pulse per received S-frame.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sq_mf_consts.svh"

module m_bit_tracker
(
   input  wire logic clock_i,
   input  wire logic rst_b_i,
   m_track_if.tracker trk
);

   sq_mf_pkg::trk_rec_type state_ff;
   sq_mf_pkg::trk_rec_type nxt_state;
   logic                   m_expect;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   assign m_expect = (state_ff.idx == `MF_FIRST_IDX);

   // Lock after a full run of correct M bits from frame 1, drop on mismatch
   always_comb
   begin
      nxt_state = state_ff;
      if (trk.m_valid)
      begin
         case (state_ff.st)
            sq_mf_pkg::TRK_HUNT:
            begin
               if (trk.m_bit)
               begin
                  nxt_state.st  = sq_mf_pkg::TRK_CHECK;
                  nxt_state.idx = 5'h01;
                  nxt_state.cnt = 5'h01;
               end
            end
            sq_mf_pkg::TRK_CHECK, sq_mf_pkg::TRK_LOCKED:
            begin
               if (trk.m_bit == m_expect)
               begin
                  nxt_state.idx = (state_ff.idx == `MF_LAST_IDX) ? `MF_FIRST_IDX : state_ff.idx + 5'h01;
                  if (state_ff.st == sq_mf_pkg::TRK_CHECK)
                  begin
                     nxt_state.cnt = state_ff.cnt + 5'h01;
                     if (state_ff.cnt + 5'h01 == `MF_FRAMES)
                        nxt_state.st = sq_mf_pkg::TRK_LOCKED;
                  end
               end
               else
               begin
                  // A stray one restarts the count as a new frame 1
                  nxt_state.st  = trk.m_bit ? sq_mf_pkg::TRK_CHECK : sq_mf_pkg::TRK_HUNT;
                  nxt_state.idx = 5'h01;
                  nxt_state.cnt = 5'h01;
               end
            end
            default:
               nxt_state.st = sq_mf_pkg::TRK_HUNT;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         state_ff <= '0;
      else
         state_ff <= nxt_state;
   end

   assign trk.locked = (state_ff.st == sq_mf_pkg::TRK_LOCKED);

   // Lock is lost on the first wrong M bit
   a_lock_lost_mismatch: assert property (
      (state_ff.st == sq_mf_pkg::TRK_LOCKED) && trk.m_valid && (trk.m_bit != m_expect)
      |=> (state_ff.st != sq_mf_pkg::TRK_LOCKED))
      else $error("lock kept after M-bit mismatch");

   // Lock is gained only after twenty correct frames
   a_lock_needs_run: assert property (
      $rose(state_ff.st == sq_mf_pkg::TRK_LOCKED) |-> ($past(state_ff.cnt) == 5'h13))
      else $error("lock gained before twenty frames");

endmodule

`default_nettype wire

// *** src/s_q_multiframe_sync.sv ***
/*
  S/Q multiframe generation and capture for the network side of the S/T line,
  with external frame trigger, external multiframe reset and terminal M-bit pin.
  Assumes the line framer supplies frame-aligned receive strobes on clock_i and
  sends the F-A, M and S bits presented here at each S-frame start.
*/
// Notes on behaviour
// - F-A one in frames 1,6,11,16; M frame 1
// - Twenty-frame count; other S/Q positions zero
// - Capture upstream Q bits into receive register
// - Any Q bit change raises change interrupt
// - Send four S bits in frames 1,6,11,16
// - Disable bit stops multiframe structure
// - 4 kHz trigger input starts each frame
// - Trigger idle low: internal frame timing
// - Sample sync at trigger fall or start
// - Sampled sync one resets to frame 1
// - Sync low: count twenty frames, wrap
// - Sync held high holds counter at frame 1
// - One low frame reaches frame 2, M zero
// - Terminal mode: M bit on sync pin with echo
// - Terminal lock after twenty correct M bits
`timescale 1ns/1ns
`default_nettype none
`include "sq_mf_consts.svh"

module s_q_multiframe_sync
#(
   parameter int FRAME_CYCLES = `FRAME_CYCLES
)
(
   input  wire logic       clock_i,
   input  wire logic       rst_b_i,
   input  wire logic       terminal_mode_i,
   input  wire logic       multiframe_disable_i,
   input  wire logic [3:0] sq_transmit_reg_i,
   input  wire logic       frame_trigger_in_i,
   input  wire logic       multiframe_sync_pin_i,
   input  wire logic       rx_fa_valid_i,
   input  wire logic       rx_fa_bit_i,
   input  wire logic       rx_m_valid_i,
   input  wire logic       rx_m_bit_i,
   input  wire logic       rx_echo_valid_i,
   input  wire logic       rx_echo_bit_i,
   output logic            frame_start_o,
   output logic [4:0]      frame_index_o,
   output logic            tx_fa_bit_o,
   output logic            tx_m_bit_o,
   output logic            tx_s_bit_o,
   output logic [3:0]      sq_receive_reg_o,
   output logic            indicate_or_sq_change_irq_o,
   output logic            multiframe_locked_o,
   output logic            multiframe_sync_pin_o,
   output logic            multiframe_sync_pin_oe_o
);

   localparam logic [15:0] FRAME_LAST = 16'(FRAME_CYCLES - 1);
   localparam logic [15:0] TRIG_HOLD  = 16'(`TRIG_HOLD_FRAMES * FRAME_CYCLES);

   sq_mf_pkg::core_state_type state_ff;
   sq_mf_pkg::core_state_type nxt_state;
   logic                      trig_level;
   logic                      msync_level;
   logic                      trig_rise;
   logic                      trig_fall;
   logic                      timer_wrap;
   logic                      ext_active;
   logic                      start;
   logic                      msync_now;
   logic                      gen_on;
   logic [4:0]                new_idx;

   m_track_if trk_bus ();

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   // Pin levels enter through two flip-flops each
   pin_sync2 u_trig_sync
   (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .pin_i   (frame_trigger_in_i),
      .level_o (trig_level)
   );

   pin_sync2 u_msync_sync
   (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .pin_i   (multiframe_sync_pin_i),
      .level_o (msync_level)
   );

   // Terminal-side multiframe lock
   m_bit_tracker u_tracker
   (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .trk     (trk_bus.tracker)
   );

   assign trk_bus.m_valid = rx_m_valid_i & terminal_mode_i;
   assign trk_bus.m_bit   = rx_m_bit_i;

   // Slot of a Q/S frame within the multiframe
   function automatic logic is_q_frame(input logic [4:0] idx);
      is_q_frame = (idx == `Q_FRAME_1_IDX) || (idx == `Q_FRAME_2_IDX) ||
                   (idx == `Q_FRAME_3_IDX) || (idx == `Q_FRAME_4_IDX);
   endfunction

   function automatic logic [1:0] q_slot(input logic [4:0] idx);
      case (idx)
         `Q_FRAME_1_IDX: q_slot = 2'h0;
         `Q_FRAME_2_IDX: q_slot = 2'h1;
         `Q_FRAME_3_IDX: q_slot = 2'h2;
         `Q_FRAME_4_IDX: q_slot = 2'h3;
         default:        q_slot = 2'h0;
      endcase
   endfunction

   // Trigger edges and frame start selection
   assign trig_rise  = trig_level & ~state_ff.trig_d;
   assign trig_fall  = ~trig_level & state_ff.trig_d;
   assign timer_wrap = (state_ff.timer == FRAME_LAST);
   assign ext_active = (state_ff.ext_age != 16'h0000);
   assign start      = trig_rise | (timer_wrap & ~ext_active);
   assign gen_on     = ~multiframe_disable_i & ~terminal_mode_i;
   // Sync value: the one taken at trigger fall, else the level at start
   assign msync_now  = state_ff.msync_taken ? state_ff.msync_val : msync_level;

   // Next multiframe index at a frame start
   always_comb
   begin
      new_idx = state_ff.frame_idx;
      if (!gen_on)
         new_idx = `MF_FIRST_IDX;
      else if (msync_now)
         new_idx = `MF_FIRST_IDX;
      else if (state_ff.frame_idx == `MF_LAST_IDX)
         new_idx = `MF_FIRST_IDX;
      else
         new_idx = state_ff.frame_idx + 5'h01;
   end

   // Whole next state of the core
   always_comb
   begin
      nxt_state             = state_ff;
      nxt_state.trig_d      = trig_level;
      nxt_state.frame_start = start;
      nxt_state.irq         = 1'b0;
      nxt_state.locked      = trk_bus.locked;

      // A trigger rising edge keeps the external timing in charge for two frames
      if (trig_rise)
         nxt_state.ext_age = TRIG_HOLD;
      else if (ext_active)
         nxt_state.ext_age = state_ff.ext_age - 16'h0001;

      // Internal frame timer restarts at every frame start
      if (start || timer_wrap)
         nxt_state.timer = 16'h0000;
      else
         nxt_state.timer = state_ff.timer + 16'h0001;

      // Sync input taken at trigger fall when that comes first
      if (trig_fall && !state_ff.msync_taken)
      begin
         nxt_state.msync_taken = 1'b1;
         nxt_state.msync_val   = msync_level;
      end

      // Frame start: step counter and present the new frame's bits
      if (start)
      begin
         nxt_state.msync_taken = 1'b0;
         nxt_state.sync_hit  = gen_on & msync_now;
         nxt_state.frame_idx = new_idx;
         nxt_state.fa        = gen_on & is_q_frame(new_idx);
         nxt_state.m         = gen_on & (new_idx == `MF_FIRST_IDX);
         nxt_state.s         = gen_on & is_q_frame(new_idx) & sq_transmit_reg_i[q_slot(new_idx)];
      end

      // Upstream Q bits caught in their frames, change flagged
      if (rx_fa_valid_i && gen_on && is_q_frame(state_ff.frame_idx))
      begin
         nxt_state.q_bits[q_slot(state_ff.frame_idx)] = rx_fa_bit_i;
         if (state_ff.q_bits[q_slot(state_ff.frame_idx)] != rx_fa_bit_i)
            nxt_state.irq = 1'b1;
      end

      // Terminal mode drives received M and echo bits on the sync pin
      nxt_state.pin_oe = terminal_mode_i;
      if (terminal_mode_i && rx_m_valid_i)
         nxt_state.pin_out = rx_m_bit_i;
      else if (terminal_mode_i && rx_echo_valid_i)
         nxt_state.pin_out = rx_echo_bit_i;
      else if (!terminal_mode_i)
         nxt_state.pin_out = 1'b0;
   end

   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         state_ff <= '0;
      else
         state_ff <= nxt_state;
   end

   // Outputs straight from the state record
   assign frame_start_o               = state_ff.frame_start;
   assign frame_index_o               = state_ff.frame_idx;
   assign tx_fa_bit_o                 = state_ff.fa;
   assign tx_m_bit_o                  = state_ff.m;
   assign tx_s_bit_o                  = state_ff.s;
   assign sq_receive_reg_o            = state_ff.q_bits;
   assign indicate_or_sq_change_irq_o = state_ff.irq;
   assign multiframe_locked_o         = state_ff.locked;
   assign multiframe_sync_pin_o       = state_ff.pin_out;
   assign multiframe_sync_pin_oe_o    = state_ff.pin_oe;

   // F-A and M patterns follow the frame index
   a_fa_m_pattern: assert property (
      frame_start_o && $past(gen_on) |->
         (tx_m_bit_o == (frame_index_o == 5'h00)) &&
         (tx_fa_bit_o == (frame_index_o == 5'h00 || frame_index_o == 5'h05 ||
                          frame_index_o == 5'h0A || frame_index_o == 5'h0F)))
      else $error("F-A or M bit wrong for frame");

   // S bit zero outside the four S frames
   a_s_zero_elsewhere: assert property (
      frame_start_o && !tx_fa_bit_o |-> !tx_s_bit_o)
      else $error("S bit set outside S frames");

   // Second S frame carries the second transmit bit
   a_s_bit_map: assert property (
      frame_start_o && $past(gen_on) && frame_index_o == 5'h05 |->
         tx_s_bit_o == $past(sq_transmit_reg_i[1]))
      else $error("S bit not taken from transmit bit 2");

   // Disabled generation holds frame 1 and sends no pattern
   a_disable_stops: assert property (
      frame_start_o && $past(multiframe_disable_i) |->
         frame_index_o == 5'h00 && !tx_m_bit_o && !tx_fa_bit_o)
      else $error("multiframe sent while disabled");

   // Trigger rising edge starts a frame on the next cycle
   a_trigger_start: assert property (
      trig_rise |=> frame_start_o)
      else $error("trigger edge gave no frame start");

   // Without trigger the timer period starts the frame
   a_internal_timing: assert property (
      timer_wrap && !ext_active |=> frame_start_o ##1 !frame_start_o)
      else $error("internal timing gave no frame start");

   // Sync taken at trigger fall
   a_sync_sample: assert property (
      trig_fall && !state_ff.msync_taken && !start |=>
         state_ff.msync_taken && state_ff.msync_val == $past(msync_level))
      else $error("sync input not sampled at trigger fall");

   // Sampled sync forces frame 1
   a_sync_reset: assert property (
      frame_start_o && state_ff.sync_hit |-> frame_index_o == 5'h00 && tx_m_bit_o)
      else $error("sync did not reset multiframe");

   // Free counting steps by one and wraps after twenty
   a_count_step: assert property (
      frame_start_o && !state_ff.sync_hit && $past(gen_on) |->
         frame_index_o == (($past(frame_index_o) == 5'h13) ? 5'h00 : $past(frame_index_o) + 5'h01))
      else $error("multiframe counter step wrong");

   // Q bit stored in its slot
   a_q_capture: assert property (
      rx_fa_valid_i && gen_on && state_ff.frame_idx == 5'h0A |=> sq_receive_reg_o[2] == $past(rx_fa_bit_i))
      else $error("Q bit 3 not captured");

   // Change interrupt only with a changed receive value
   a_change_irq: assert property (
      indicate_or_sq_change_irq_o |-> sq_receive_reg_o != $past(sq_receive_reg_o))
      else $error("change interrupt without Q change");

   // Terminal pin shows the received M bit
   a_m_on_pin: assert property (
      terminal_mode_i && rx_m_valid_i |=> multiframe_sync_pin_oe_o && multiframe_sync_pin_o == $past(rx_m_bit_i))
      else $error("M bit not shown on sync pin");

endmodule

`default_nettype wire

// *** testbench/sq_line_partner.sv ***
/*
  Far-side terminal model: upstream Q bit in every frame, plus M and echo
  strobes on its own frame timing for terminal-mode runs.
  Assumes the block's frame start and index arrive on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module sq_line_partner
#(
   parameter int FRAME = 40
)
(
   input  wire logic       clock_i,
   input  wire logic       rst_b_i,
   input  wire logic       frame_start_i,
   input  wire logic [4:0] frame_index_i,
   input  wire logic [3:0] q_pattern_i,
   input  wire logic       m_err_i,
   output logic            fa_valid_o,
   output logic            fa_bit_o,
   output logic            m_valid_o,
   output logic            m_bit_o,
   output logic            echo_valid_o,
   output logic            echo_bit_o
);
   logic [7:0] since_ff;
   logic [7:0] tick_ff;
   logic [4:0] mf_ff;
   logic [4:0] slot;

   assign slot = frame_index_i / 5'h05;

   // Q bit six cycles after the frame start pulse; between strobes the line shows junk
   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         since_ff   <= 8'hff;
         fa_valid_o <= 1'b0;
         fa_bit_o   <= 1'b0;
      end
      else
      begin
         if (frame_start_i)
            since_ff <= 8'h00;
         else if (since_ff != 8'hff)
            since_ff <= since_ff + 8'h01;
         fa_valid_o <= (since_ff == 8'h04);
         if (since_ff == 8'h04)
            fa_bit_o <= (frame_index_i % 5'h05 == 5'h00) && q_pattern_i[slot[1:0]];
         else
            fa_bit_o <= ~fa_bit_o;
      end
   end

   // M strobe at tick 0 with the 20-frame pattern, echo strobe at tick 3
   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         tick_ff      <= 8'h00;
         mf_ff        <= 5'h00;
         m_valid_o    <= 1'b0;
         m_bit_o      <= 1'b0;
         echo_valid_o <= 1'b0;
         echo_bit_o   <= 1'b0;
      end
      else
      begin
         tick_ff <= (tick_ff == 8'(FRAME - 1)) ? 8'h00 : tick_ff + 8'h01;
         if (tick_ff == 8'h00)
            mf_ff <= (mf_ff == 5'h13) ? 5'h00 : mf_ff + 5'h01;
         m_valid_o    <= (tick_ff == 8'h00);
         m_bit_o      <= (tick_ff == 8'h00) ? ((mf_ff == 5'h00) ^ m_err_i) : ~m_bit_o;
         echo_valid_o <= (tick_ff == 8'h03);
         echo_bit_o   <= (tick_ff == 8'h03) ? mf_ff[1] : ~echo_bit_o;
      end
   end
endmodule

`default_nettype wire

// *** testbench/s_q_multiframe_sync_bench.sv ***
/*
  Self-checking bench of the S/Q multiframe block: internal and triggered
  frame timing, sync pin, Q capture, disable and terminal M pin with lock.
  Assumes FRAME_CYCLES scaled to 40 and a 30-cycle external trigger.
*/
`timescale 1ns/1ns
`default_nettype none

module s_q_multiframe_sync_bench;
   logic        clock_i;
   logic        rst_b_i;
   logic        terminal;
   logic        dis;
   logic [3:0]  tx;
   logic        trig;
   logic        trig_on;
   logic        msync;
   logic        msync_wire;
   logic [3:0]  qpat;
   logic        m_err;
   logic        fa_v, fa_b, m_v, m_b, e_v, e_b;
   logic        fstart, tx_fa, tx_m, tx_s, irq, locked, pin, pin_oe;
   logic [4:0]  findex;
   logic [3:0]  sqr;
   logic [4:0]  cur_idx;
   logic [3:0]  exp_sqr;
   logic [20:0] notes[$];
   logic [20:0] exp_n;
   logic [7:0]  gap;
   logic        irq_seen;
   logic        mb;
   integer      seed, num_errors, checks, f;

   // Wire level of the two-way sync pin
   assign msync_wire = pin_oe ? pin : msync;

   s_q_multiframe_sync #(.FRAME_CYCLES(40)) dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
      .terminal_mode_i(terminal), .multiframe_disable_i(dis), .sq_transmit_reg_i(tx),
      .frame_trigger_in_i(trig), .multiframe_sync_pin_i(msync_wire), .rx_fa_valid_i(fa_v),
      .rx_fa_bit_i(fa_b), .rx_m_valid_i(m_v), .rx_m_bit_i(m_b), .rx_echo_valid_i(e_v),
      .rx_echo_bit_i(e_b), .frame_start_o(fstart), .frame_index_o(findex), .tx_fa_bit_o(tx_fa),
      .tx_m_bit_o(tx_m), .tx_s_bit_o(tx_s), .sq_receive_reg_o(sqr),
      .indicate_or_sq_change_irq_o(irq), .multiframe_locked_o(locked),
      .multiframe_sync_pin_o(pin), .multiframe_sync_pin_oe_o(pin_oe));

   sq_line_partner #(.FRAME(40)) partner (.clock_i(clock_i), .rst_b_i(rst_b_i),
      .frame_start_i(fstart), .frame_index_i(findex), .q_pattern_i(qpat), .m_err_i(m_err),
      .fa_valid_o(fa_v), .fa_bit_o(fa_b), .m_valid_o(m_v), .m_bit_o(m_b),
      .echo_valid_o(e_v), .echo_bit_o(e_b));

   // Clock, 10 ns period
   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   task automatic end_sim;
      if (num_errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input logic [20:0] seen, input logic [20:0] exp);
      checks = checks + 1;
      if (seen !== exp)
      begin
         num_errors = num_errors + 1;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Bounded wait at falling edges: 0 frame start, 1 M strobe, 2 echo strobe
   task automatic wait_for(input int sel);
      int   n;
      logic hit;
      hit = 1'b0;
      for (n = 0; n < 200 && !hit; n++)
      begin
         @(negedge clock_i);
         hit = (sel == 0) ? fstart === 1'b1 : (sel == 1) ? m_v === 1'b1 : e_v === 1'b1;
      end
      if (!hit)
      begin
         num_errors = num_errors + 1;
         end_sim();
      end
   endtask

   // Expected view of a frame start: gap, change flag, Q register, index, F-A, M, S
   function automatic logic [20:0] note_of(input logic [7:0] g, input logic c, input logic [4:0] i);
      logic q;
      q = !dis && (i % 5 == 0);
      return {g, c, exp_sqr, i, q, !dis && i == 5'h00, q && tx[i / 5]};
   endfunction

   // Drive next frame's inputs, then note what the following start must show
   task automatic step(input logic [7:0] gap_e);
      logic [4:0] nxt;
      logic       chg;
      int         sl;
      tx = 4'($random(seed));
      qpat = 4'($random(seed));
      chg = 1'b0;
      sl = cur_idx / 5;
      if (!dis && cur_idx % 5 == 0)
      begin
         chg = exp_sqr[sl] != qpat[sl];
         exp_sqr[sl] = qpat[sl];
      end
      nxt = (dis || msync) ? 5'h00 : (cur_idx == 5'h13) ? 5'h00 : cur_idx + 5'h01;
      notes.push_back(note_of(gap_e, chg, nxt));
      cur_idx = nxt;
   endtask

   task automatic wait_start;
      wait_for(0);
      @(posedge clock_i);
      #1;
   endtask

   // Scoreboard: each frame start takes the oldest note
   initial
   begin
      gap = 8'h00;
      irq_seen = 1'b0;
      forever
      begin
         @(negedge clock_i);
         gap = gap + 8'h01;
         if (fstart === 1'b1 && notes.size() > 0)
         begin
            exp_n = notes.pop_front();
            check({exp_n[20:13] == 8'h00 ? 8'h00 : gap, irq_seen, sqr, findex, tx_fa, tx_m, tx_s},
                  exp_n);
         end
         if (fstart === 1'b1)
         begin
            gap = 8'h00;
            irq_seen = 1'b0;
         end
         if (irq === 1'b1)
            irq_seen = 1'b1;
      end
   end

   // External frame trigger, 30-cycle period, high for 10 cycles
   initial
   begin
      trig = 1'b0;
      forever
      begin
         @(posedge clock_i);
         if (trig_on)
         begin
            #1 trig = 1'b1;
            repeat (10) @(posedge clock_i);
            #1 trig = 1'b0;
            repeat (19) @(posedge clock_i);
         end
      end
   end

   // Main sequence
   initial
   begin
      seed = 59582;
      num_errors = 0;
      checks = 0;
      rst_b_i = 1'b0;
      {terminal, dis, tx, msync, qpat, m_err, trig_on} = 13'h0000;
      // Reset leaves the counter at frame 1, so the first start steps to frame 2
      cur_idx = 5'h01;
      exp_sqr = 4'h0;
      repeat (12) @(posedge clock_i);
      check({fstart, findex, sqr, irq, pin_oe}, 21'h0);
      #1 rst_b_i = 1'b1;
      notes.push_back(note_of(8'h00, 1'b0, cur_idx));
      // Internal timing, trigger idle low; sync held, one-frame gap, then free run
      for (f = 0; f < 30; f++)
      begin
         wait_start();
         msync = (f < 2 || f == 3);
         step(f == 0 ? 8'h00 : 8'h28);
      end
      check(pin_oe, 1'b0);
      // Triggered timing; sync pulse drops after trigger fall, before the next start
      wait_start();
      step(8'h00);
      repeat (20) @(posedge clock_i);
      #1 trig_on = 1'b1;
      for (f = 0; f < 25; f++)
      begin
         wait_start();
         msync = (f == 10);
         step(f == 0 ? 8'h00 : 8'h1e);
         if (f == 10)
         begin
            repeat (15) @(posedge clock_i);
            #1 msync = 1'b0;
         end
      end
      // Generation disabled: all framing bits zero, no capture
      for (f = 0; f < 3; f++)
      begin
         wait_start();
         dis = 1'b1;
         msync = 1'b1;
         step(f == 2 ? 8'h00 : 8'h1e);
      end
      trig_on = 1'b0;
      dis = 1'b0;
      terminal = 1'b1;
      // Terminal mode: M and echo on the pin, lock, then one bad M bit
      for (f = 0; f < 46; f++)
      begin
         if (f == 44)
            check(locked, 1'b1);
         @(posedge clock_i);
         #1 m_err = (f == 45);
         wait_for(1);
         mb = m_b;
         @(negedge clock_i);
         check({pin, pin_oe}, {mb, 1'b1});
         wait_for(2);
         mb = e_b;
         @(negedge clock_i);
         check(pin, mb);
      end
      check(locked, 1'b0);
      end_sim();
   end
endmodule

`default_nettype wire
